// >>> inc/cps_pkg.sv
// constants and field layouts shared by the control pin setting selector
package cps_pkg;

    // structure of the stored settings
    localparam int NUM_PLL = 4;
    localparam int NUM_SETTING = 8;
    localparam int IDX_W = 3;
    localparam int SSC_W = 3;
    localparam int QTR_W = 4;
    localparam int STATE_W = 2;
    localparam int PLL_FIELD_W = 5;
    localparam int SET_W = 21;
    localparam int GEN_W = 7;
    localparam int PLL_W = 6;

    // avalon slave geometry
    localparam int ADDR_W = 7;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;
    localparam int WORD_W = 5;
    localparam int WORD_LSB = 2;

    // word indices (byte offset is four times the index)
    localparam logic [WORD_W-1:0] WORD_GENERIC = 5'h00;
    localparam logic [WORD_W-1:0] WORD_STATUS = 5'h01;
    localparam logic [WORD_W-1:0] WORD_COMMAND = 5'h02;
    localparam logic [WORD_W-1:0] WORD_ACTIVE = 5'h03;
    localparam logic [2:0] PLL_GROUP = 3'h1;
    localparam logic [1:0] SET_GROUP = 2'h1;

    // output state codes
    localparam logic [STATE_W-1:0] ST_POWER_DOWN = 2'h0;
    localparam logic [STATE_W-1:0] ST_HIGH_Z = 2'h1;
    localparam logic [STATE_W-1:0] ST_DRIVE_LOW = 2'h2;
    localparam logic [STATE_W-1:0] ST_ACTIVE = 2'h3;

    // generic register fields
    localparam int GEN_ST0_LSB = 0;
    localparam int GEN_ST1_LSB = 2;
    localparam int GEN_PIN_ROLE_BIT = 6;

    // pll configuration register fields
    localparam int PLL_DOWN_BIT = 0;
    localparam int PLL_ST0_LSB = 1;
    localparam int PLL_ST1_LSB = 3;
    localparam int PLL_BYPASS_BIT = 5;

    // setting word fields; pll p field starts at SET_PLL_LSB + 5*p
    localparam int SET_Y1_BIT = 0;
    localparam int SET_PLL_LSB = 1;
    localparam int PF_FS_BIT = 0;
    localparam int PF_SSC_LSB = 1;
    localparam int PF_OUT_BIT = 4;

    // status and command fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_SELMODE_BIT = 1;
    localparam int STAT_IDX_LSB = 2;
    localparam int STAT_NV_ROLE_BIT = 5;
    localparam int STAT_SUPPLY_BIT = 6;
    localparam int CMD_EEP_WRITE_BIT = 0;

    // factory defaults: pass-through, output_state_zero high-z, output_state_one active
    localparam logic [GEN_W-1:0] GEN_DEFAULT = 7'h0d;
    localparam logic [PLL_W-1:0] PLL_DEFAULT = 6'h3a;
    localparam logic [SET_W-1:0] SET0_DEFAULT = 21'h000000;
    localparam logic [SET_W-1:0] SET1_DEFAULT = 21'h108421;

    // spread code 7 jumps to eight quarter steps
    localparam logic [SSC_W-1:0] SSC_TOP_CODE = 3'h7;
    localparam logic [QTR_W-1:0] SSC_TOP_QUARTERS = 4'h8;

    // nonvolatile write duration
    localparam int CLK_PERIOD_NS = 100;
    localparam int EEP_WRITE_TIME_NS = 100000;
    localparam int BUSY_W = 11;
    localparam logic [BUSY_W-1:0] EEP_WRITE_CYCLES =
        BUSY_W'(EEP_WRITE_TIME_NS / CLK_PERIOD_NS);
    localparam logic [BUSY_W-1:0] BUSY_LAST = 11'h001;

endpackage

// >>> logic/cps_control_select.sv
// control pin setting selector with avalon register access
// Function
// - eight stored settings, the one picked by the selector pins is applied
// - 3-bit spread code: off, quarter percent steps to 1.5, code 7 is 2.0
// - spread type, bypass and output states come from pll registers
// - frequency bit 0 picks first frequency, 1 picks second
// - pll output bit picks state 0 or 1 for both outputs of that pll
// - first output bit picks generic state 0 or 1
// - first output selection also acts as device power-down selection
// - shared pins are serial by default; stored role bit makes them selectors
// - volatile role bit has no effect until written to nonvolatile store
// - as selectors the shared pins no longer serve the serial slave
// - grounded output supply forces shared pins back to serial role
// - dedicated pin is always and only a selector input
// - shared pins in serial role count as zero in the selector index
// - after power-up the nonvolatile settings are loaded and kept
// - factory default passes the input frequency straight through
// - default: index 0 high-z, index 1 active, frequency 0, spread off
// - in default mode only settings 0 and 1, picked by dedicated pin
// - serial slave on a two-wire bus with 7-bit addressing
// - serial transfers at standard and fast mode rates
//
// The address map and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

module cps_control_select
    import cps_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [DATA_W-1:0] avsWritedata,
    input wire logic [BE_W-1:0] avsByteenable,
    output logic [DATA_W-1:0] avsReaddata,
    output logic avsWaitrequest,
    // selector pins
    input wire logic dedicatedSelectPin,
    input wire logic sharedSelectPinDataIn,
    output logic sharedSelectPinDataOut,
    output logic sharedSelectPinDataOeN,
    input wire logic sharedSelectPinClock,
    input wire logic outputSupplyGrounded,
    // serial slave engine hookup
    output logic engineSdaIn,
    output logic engineSclIn,
    output logic engineEnable,
    input wire logic engineSdaDriveLow,
    // applied setting
    output logic [IDX_W-1:0] activeIndex,
    output logic [NUM_PLL-1:0][SSC_W-1:0] spreadCodeField,
    output logic [NUM_PLL-1:0][QTR_W-1:0] spreadQuarterSteps,
    output logic [NUM_PLL-1:0] spreadDown,
    output logic [NUM_PLL-1:0] freqChoiceBit,
    output logic [NUM_PLL-1:0] pllBypass,
    output logic [NUM_PLL-1:0][STATE_W-1:0] pllOutputState,
    output logic [STATE_W-1:0] firstOutputState,
    output logic devicePowerDown
);

    typedef struct packed {
        // pin synchronisers
        logic [1:0] dedSync;
        logic [1:0] dataSync;
        logic [1:0] clkSync;
        logic [1:0] supSync;

        // volatile and stored images
        logic [NUM_SETTING-1:0][SET_W-1:0] volSet;
        logic [NUM_SETTING-1:0][SET_W-1:0] nvSet;
        logic [GEN_W-1:0] volGen;
        logic [GEN_W-1:0] nvGen;
        logic [NUM_PLL-1:0][PLL_W-1:0] volPll;
        logic [NUM_PLL-1:0][PLL_W-1:0] nvPll;

        // write timer, power-up copy
        logic [BUSY_W-1:0] busyCnt;
        logic bootLoad;

        // bus handshake
        logic ack;
        logic [DATA_W-1:0] rdData;

        // role and applied setting
        logic selMode;
        logic [IDX_W-1:0] idx;
        logic [SET_W-1:0] activeSet;
        logic [NUM_PLL-1:0][SSC_W-1:0] ssc;
        logic [NUM_PLL-1:0][QTR_W-1:0] qtr;
        logic [NUM_PLL-1:0] down;
        logic [NUM_PLL-1:0] fs;
        logic [NUM_PLL-1:0] bypass;
        logic [NUM_PLL-1:0][STATE_W-1:0] pllState;
        logic [STATE_W-1:0] y1State;
        logic powerDown;

        // serial engine levels
        logic engSda;
        logic engScl;
        logic engEn;
        logic sdaDriveN;
    } cps_state_type;

    // one record holds all state
    cps_state_type state_r;
    cps_state_type state_nxt;

    // byte lane merge for partial writes
    function automatic logic [DATA_W-1:0] cps_merge(
        input logic [DATA_W-1:0] old,
        input logic [DATA_W-1:0] wr,
        input logic [BE_W-1:0] be
    );
        logic [DATA_W-1:0] res;
        // lanes not enabled keep old value
        res = old;
        for (int b = 0; b < BE_W; b++)
        begin
            if (be[b])
            begin
                res[8*b +: 8] = wr[8*b +: 8];
            end
        end
        return res;
    endfunction

    // spread code to quarter percent steps
    function automatic logic [QTR_W-1:0] cps_quarters(
        input logic [SSC_W-1:0] code
    );
        return (code == SSC_TOP_CODE) ? SSC_TOP_QUARTERS : {1'b0, code};
    endfunction

    // pick one of two state codes by a select bit
    function automatic logic [STATE_W-1:0] cps_pick(
        input logic sel,
        input logic [STATE_W-1:0] st0,
        input logic [STATE_W-1:0] st1
    );
        return sel ? st1 : st0;
    endfunction

    // next-state logic
    always_comb
    begin
        // scratch, set before use
        logic serialRole;
        logic [IDX_W-1:0] idx;
        logic [SET_W-1:0] set;
        logic [PLL_FIELD_W-1:0] fld;
        logic [PLL_W-1:0] cfg;
        logic [WORD_W-1:0] word;
        logic [DATA_W-1:0] rd;
        logic [DATA_W-1:0] mrg;
        logic req;
        serialRole = 1'b0;
        idx = '0;
        set = '0;
        fld = '0;
        cfg = '0;
        rd = '0;
        mrg = '0;
        word = avsAddress[ADDR_W-1:WORD_LSB];
        req = avsRead | avsWrite;

        // fields hold unless changed below
        state_nxt = state_r;

        // two-stage synchronisers for every pin input
        state_nxt.dedSync = {state_r.dedSync[0], dedicatedSelectPin};
        state_nxt.dataSync = {state_r.dataSync[0], sharedSelectPinDataIn};
        state_nxt.clkSync = {state_r.clkSync[0], sharedSelectPinClock};
        state_nxt.supSync = {state_r.supSync[0], outputSupplyGrounded};

        // pin role follows the stored copy only; supply override wins
        // the volatile bit would let a bus write
        // cut the link in mid frame
        serialRole = ~state_r.nvGen[GEN_PIN_ROLE_BIT]
            | state_r.supSync[1];
        state_nxt.selMode = ~serialRole;

        // index: shared pins read as zero while serial
        // masking first keeps serial traffic
        // off the applied setting
        idx = {state_r.clkSync[1] & ~serialRole,
               state_r.dataSync[1] & ~serialRole,
               state_r.dedSync[1]};
        state_nxt.idx = idx;
        set = state_r.volSet[idx];
        state_nxt.activeSet = set;

        // decode the applied setting per pll
        // quarter steps spare a second decode
        for (int p = 0; p < NUM_PLL; p++)
        begin
            fld = set[SET_PLL_LSB + PLL_FIELD_W*p +: PLL_FIELD_W];
            cfg = state_r.volPll[p];
            state_nxt.ssc[p] = fld[PF_SSC_LSB +: SSC_W];
            state_nxt.qtr[p] = cps_quarters(fld[PF_SSC_LSB +: SSC_W]);
            state_nxt.down[p] = cfg[PLL_DOWN_BIT];
            state_nxt.fs[p] = fld[PF_FS_BIT];
            state_nxt.bypass[p] = cfg[PLL_BYPASS_BIT];
            state_nxt.pllState[p] = cps_pick(fld[PF_OUT_BIT],
                cfg[PLL_ST0_LSB +: STATE_W], cfg[PLL_ST1_LSB +: STATE_W]);
        end
        state_nxt.y1State = cps_pick(set[SET_Y1_BIT],
            state_r.volGen[GEN_ST0_LSB +: STATE_W],
            state_r.volGen[GEN_ST1_LSB +: STATE_W]);
        state_nxt.powerDown = (state_nxt.y1State == ST_POWER_DOWN);

        // serial engine sees the pins only in serial role, else idle high
        // idle-high lines: no start from selector traffic
        state_nxt.engEn = serialRole;
        state_nxt.engSda = serialRole ? state_r.dataSync[1] : 1'b1;
        state_nxt.engScl = serialRole ? state_r.clkSync[1] : 1'b1;
        state_nxt.sdaDriveN = ~(serialRole & engineSdaDriveLow);

        // first cycle after reset copies the stored image in
        // no bus write lands before edge 2
        if (state_r.bootLoad)
        begin
            state_nxt.bootLoad = 1'b0;
            state_nxt.volSet = state_r.nvSet;
            state_nxt.volGen = state_r.nvGen;
            state_nxt.volPll = state_r.nvPll;
        end

        // nonvolatile write: image copied when the busy time runs out
        // whole image at once; role moves
        // only when the write is done
        if (state_r.busyCnt != '0)
        begin
            state_nxt.busyCnt = state_r.busyCnt - BUSY_LAST;
            if (state_r.busyCnt == BUSY_LAST)
            begin
                state_nxt.nvSet = state_r.volSet;
                state_nxt.nvGen = state_r.volGen;
                state_nxt.nvPll = state_r.volPll;
            end
        end

        // read mux, captured in the wait cycle
        // unmapped and command words read 0
        if (word == WORD_GENERIC)
        begin
            rd = DATA_W'(state_r.volGen);
        end
        else if (word == WORD_STATUS)
        begin
            rd[STAT_BUSY_BIT] = (state_r.busyCnt != '0);
            rd[STAT_SELMODE_BIT] = state_r.selMode;
            rd[STAT_IDX_LSB +: IDX_W] = state_r.idx;
            rd[STAT_NV_ROLE_BIT] = state_r.nvGen[GEN_PIN_ROLE_BIT];
            rd[STAT_SUPPLY_BIT] = state_r.supSync[1];
        end
        else if (word == WORD_ACTIVE)
        begin
            rd = DATA_W'(state_r.activeSet);
        end
        else if (word[WORD_W-1:2] == PLL_GROUP)
        begin
            rd = DATA_W'(state_r.volPll[word[1:0]]);
        end
        else if (word[WORD_W-1:3] == SET_GROUP)
        begin
            rd = DATA_W'(state_r.volSet[word[2:0]]);
        end

        // one wait state per access; the write lands on the release edge
        state_nxt.ack = req & ~state_r.ack;
        if (req & ~state_r.ack)
        begin
            state_nxt.rdData = avsRead ? rd : '0;
        end

        // writes are dropped while the nonvolatile write runs
        // merge keeps untouched fields
        if (avsWrite & state_r.ack & (state_r.busyCnt == '0))
        begin
            mrg = cps_merge(rd, avsWritedata, avsByteenable);
            if (word == WORD_GENERIC)
            begin
                state_nxt.volGen = mrg[GEN_W-1:0];
            end
            else if (word == WORD_COMMAND)
            begin
                if (avsByteenable[0] & avsWritedata[CMD_EEP_WRITE_BIT])
                begin
                    state_nxt.busyCnt = EEP_WRITE_CYCLES;
                end
            end
            else if (word[WORD_W-1:2] == PLL_GROUP)
            begin
                state_nxt.volPll[word[1:0]] = mrg[PLL_W-1:0];
            end
            else if (word[WORD_W-1:3] == SET_GROUP)
            begin
                state_nxt.volSet[word[2:0]] = mrg[SET_W-1:0];
            end
        end
    end

    // state register; reset loads the factory image
    // resetn stands for power-up
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r <= '0;
            for (int k = 0; k < NUM_SETTING; k++)
            begin
                // odd settings enable, even ones high-z
                state_r.nvSet[k] <= k[0] ? SET1_DEFAULT : SET0_DEFAULT;
                state_r.volSet[k] <= k[0] ? SET1_DEFAULT : SET0_DEFAULT;
            end
            for (int p = 0; p < NUM_PLL; p++)
            begin
                state_r.nvPll[p] <= PLL_DEFAULT;
                state_r.volPll[p] <= PLL_DEFAULT;
            end
            state_r.nvGen <= GEN_DEFAULT;
            state_r.volGen <= GEN_DEFAULT;
            state_r.bootLoad <= 1'b1;

            // engine lines start idle high
            state_r.engSda <= 1'b1;
            state_r.engScl <= 1'b1;
            state_r.engEn <= 1'b1;
            state_r.sdaDriveN <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // bus handshake is combinational, data from flops
    // every access costs two cycles
    assign avsWaitrequest = (avsRead | avsWrite) & ~state_r.ack;
    assign avsReaddata = state_r.rdData;

    // open-drain data pin only ever pulls low
    // fixed level, moving enable: the pin
    // never drives high on the wire
    assign sharedSelectPinDataOut = 1'b0;
    assign sharedSelectPinDataOeN = state_r.sdaDriveN;

    // engine hookup from flops
    assign engineSdaIn = state_r.engSda;
    assign engineSclIn = state_r.engScl;
    assign engineEnable = state_r.engEn;

    // applied setting outputs
    assign activeIndex = state_r.idx;

    // spread code, amount, direction
    assign spreadCodeField = state_r.ssc;
    assign spreadQuarterSteps = state_r.qtr;
    assign spreadDown = state_r.down;

    // frequency, bypass, output states
    assign freqChoiceBit = state_r.fs;
    assign pllBypass = state_r.bypass;
    assign pllOutputState = state_r.pllState;
    assign firstOutputState = state_r.y1State;
    assign devicePowerDown = state_r.powerDown;

endmodule

`default_nettype wire

// >>> tb/cps_bus_master_model.sv
// two-wire bus master model that also holds static levels on shared pins
`timescale 1ns/1ps
`default_nettype none

module cps_bus_master_model #(
    parameter int HALF = 13,
    parameter logic [6:0] TARGET_ADDR = 7'h2a // value is arbitrary
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // bench control
    input wire logic go,
    input wire logic selData,
    input wire logic selClk,
    output logic frameBusy,
    // bus wires
    input wire logic devOeN,
    output logic sdaLine,
    output logic sclLine
);
    logic [8:0] shift_r;
    logic [3:0] bitN_r;
    int cnt_r;
    logic sclG_r;
    logic sdaG_r;

    // device only pulls the data wire low; outside frames the clock stands
    assign sdaLine = (frameBusy ? sdaG_r : selData) & devOeN;
    assign sclLine = frameBusy ? sclG_r : selClk;

    // start, 7-bit address and write bit msb first, released ack, stop
    // half period of 13 cycles gives 384 kbps, inside fast mode
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            frameBusy <= 1'b0;
            sclG_r <= 1'b1;
            sdaG_r <= 1'b1;
            cnt_r <= 0;
            bitN_r <= 4'h0;
            shift_r <= 9'h1ff;
        end
        else if (!frameBusy)
        begin
            if (go)
            begin
                frameBusy <= 1'b1;
                sdaG_r <= 1'b0;
                cnt_r <= 0;
                bitN_r <= 4'h0;
                shift_r <= {TARGET_ADDR, 1'b0, 1'b1};
            end
        end
        else if (cnt_r < HALF - 1)
            cnt_r <= cnt_r + 1;
        else
        begin
            cnt_r <= 0;
            if (sclG_r && bitN_r == 4'ha)
            begin
                sdaG_r <= 1'b1;
                frameBusy <= 1'b0;
            end
            else
            begin
                sclG_r <= ~sclG_r;
                if (sclG_r)
                begin
                    sdaG_r <= (bitN_r == 4'h9) ? 1'b0 : shift_r[8];
                    shift_r <= {shift_r[7:0], 1'b1};
                    bitN_r <= bitN_r + 4'h1;
                end
            end
        end
    end
endmodule

`default_nettype wire

// >>> tb/cps_control_select_assertions.sv
// port-level checker for the control pin setting selector
`timescale 1ns/1ps
`default_nettype none

module cps_checker
    import cps_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // bus and pins
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic avsWaitrequest,
    input wire logic dedicatedSelectPin,
    input wire logic outputSupplyGrounded,
    input wire logic sharedSelectPinDataOeN,
    // serial engine hookup
    input wire logic engineSdaIn,
    input wire logic engineSclIn,
    input wire logic engineEnable,
    input wire logic engineSdaDriveLow,
    // applied setting
    input wire logic [IDX_W-1:0] activeIndex,
    input wire logic [NUM_PLL-1:0][SSC_W-1:0] spreadCodeField,
    input wire logic [NUM_PLL-1:0][QTR_W-1:0] spreadQuarterSteps,
    input wire logic [STATE_W-1:0] firstOutputState,
    input wire logic devicePowerDown
);
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    // at most one wait cycle per access
    a_one_wait: assert property ((avsRead || avsWrite) && avsWaitrequest
        |=> !avsWaitrequest)
        else $error("waitrequest held past one cycle");
    // data pin driven only in serial role at the engine's request
    a_oe_cause: assert property (!sharedSelectPinDataOeN
        |-> engineEnable && $past(engineSdaDriveLow))
        else $error("data pin driven without serial request");
    a_idle_engine: assert property (!engineEnable
        |-> engineSdaIn && engineSclIn)
        else $error("engine sees pin levels in selector role");
    a_supply_serial: assert property (outputSupplyGrounded[*4]
        |-> engineEnable)
        else $error("grounded supply did not restore serial role");
    a_serial_index: assert property (engineEnable[*2]
        |-> activeIndex[2:1] == 2'b00)
        else $error("shared pins counted while serial");
    // dedicated pin reaches index bit 0 three edges after it moves
    a_index_ded: assert property ($rose(dedicatedSelectPin)
        ##1 $stable(dedicatedSelectPin)[*2] |=> activeIndex[0])
        else $error("dedicated pin not applied");
    a_spread_top: assert property (
        (spreadCodeField[0] == SSC_TOP_CODE)
        == (spreadQuarterSteps[0] == SSC_TOP_QUARTERS))
        else $error("top spread code amount wrong");
    // compared only on a change so the reset transient is skipped
    a_power_down: assert property ($changed(firstOutputState)
        |-> devicePowerDown == (firstOutputState == ST_POWER_DOWN))
        else $error("power-down does not follow first output");
endmodule

bind cps_control_select cps_checker i_cps_checker (
    .mclk, .resetn, .avsRead, .avsWrite, .avsWaitrequest,
    .dedicatedSelectPin, .outputSupplyGrounded, .sharedSelectPinDataOeN,
    .engineSdaIn, .engineSclIn, .engineEnable, .engineSdaDriveLow,
    .activeIndex, .spreadCodeField, .spreadQuarterSteps,
    .firstOutputState, .devicePowerDown
);

`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the control pin setting selector
`timescale 1ns/1ps
`default_nettype none

module testbench
    import cps_pkg::*;
;
    logic mclk, resetn, avsRead, avsWrite, avsWaitrequest, go, frameBusy;
    logic [ADDR_W-1:0] avsAddress;
    logic [DATA_W-1:0] avsWritedata, avsReaddata, q;
    logic [BE_W-1:0] avsByteenable;
    logic dedicatedSelectPin, sharedSelectPinDataIn, sharedSelectPinClock;
    logic sharedSelectPinDataOut, sharedSelectPinDataOeN, outputSupplyGrounded;
    logic engineSdaIn, engineSclIn, engineEnable, engineSdaDriveLow;
    logic selData, selClk, devicePowerDown;
    logic [IDX_W-1:0] activeIndex;
    logic [NUM_PLL-1:0][SSC_W-1:0] spreadCodeField;
    logic [NUM_PLL-1:0][QTR_W-1:0] spreadQuarterSteps;
    logic [NUM_PLL-1:0] spreadDown, freqChoiceBit, pllBypass;
    logic [NUM_PLL-1:0][STATE_W-1:0] pllOutputState;
    logic [STATE_W-1:0] firstOutputState;
    int badCount, totalChecks, n;

    cps_control_select i_cps_control_select (
        .mclk, .resetn, .avsAddress, .avsRead, .avsWrite, .avsWritedata,
        .avsByteenable, .avsReaddata, .avsWaitrequest, .dedicatedSelectPin,
        .sharedSelectPinDataIn, .sharedSelectPinDataOut,
        .sharedSelectPinDataOeN, .sharedSelectPinClock, .outputSupplyGrounded,
        .engineSdaIn, .engineSclIn, .engineEnable, .engineSdaDriveLow,
        .activeIndex, .spreadCodeField, .spreadQuarterSteps, .spreadDown,
        .freqChoiceBit, .pllBypass, .pllOutputState, .firstOutputState,
        .devicePowerDown
    );

    cps_bus_master_model i_cps_bus_master_model (
        .mclk, .resetn, .go, .selData, .selClk, .frameBusy,
        .devOeN(sharedSelectPinDataOeN), .sdaLine(sharedSelectPinDataIn),
        .sclLine(sharedSelectPinClock)
    );

    // 10 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic stopTest;
        if (badCount == 0 && totalChecks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s, e);
        totalChecks++;
        if (s !== e)
        begin
            badCount++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask

    // one avalon access, held until waitrequest is sampled low
    task automatic acc(input logic wr, input logic [4:0] w, [31:0] d);
        int k;
        @(posedge mclk);
        avsAddress <= {w, 2'b00};
        avsWritedata <= d;
        avsWrite <= wr;
        avsRead <= ~wr;
        k = 0;
        // wait is looked at mid-cycle, where it has settled
        do
        begin
            @(negedge mclk);
            k++;
        end
        while (avsWaitrequest !== 1'b0 && k < 50);
        if (avsWaitrequest !== 1'b0)
            badCount++;
        @(posedge mclk);
        q = avsReaddata;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
    endtask

    // pins are {clock pin, data pin, dedicated pin}; decode needs 3 edges
    task automatic pins(input logic [2:0] k);
        @(posedge mclk);
        {selClk, selData, dedicatedSelectPin} <= k;
        repeat (5) @(posedge mclk);
    endtask

    // watchdog well above the expected run of about 1500 cycles
    initial
    begin
        repeat (30000) @(posedge mclk);
        badCount++;
        stopTest();
    end

    initial
    begin
        {resetn, avsRead, avsWrite, go, outputSupplyGrounded} = 5'h00;
        {engineSdaDriveLow, dedicatedSelectPin} = 2'h0;
        {selData, selClk} = 2'h3;
        avsAddress = 7'h00;
        avsWritedata = 32'h0;
        avsByteenable = 4'hf;
        badCount = 0;
        totalChecks = 0;
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        // factory image, unmapped word and write-only command read as zero
        acc(1'b0, WORD_GENERIC, 32'h0);
        chk("generic", q, 32'h0000000d);
        for (int w = 2; w < 32; w++)
        begin
            acc(1'b0, 5'(w), 32'h0);
            if (w != 3)
                chk("image", q, (w > 15 || w == 2) ? 32'h0 : (w < 8 ? 32'h3a
                    : (w[0] ? {11'h0, SET1_DEFAULT} : 32'h0)));
        end
        // default mode: shared pins idle high yet only index 0 or 1
        for (int k = 6; k < 8; k++)
        begin
            pins(3'(k));
            chk("index", activeIndex, k - 6);
            chk("y1", firstOutputState, k[0] ? ST_ACTIVE : ST_HIGH_Z);
            chk("plls", pllOutputState, {4{k[0] ? ST_ACTIVE : ST_HIGH_Z}});
            chk("fs ssc", {freqChoiceBit, spreadCodeField}, 16'h0);
            chk("bypass", pllBypass, 4'hf);
        end
        // a real frame, then the engine pulls the data wire low
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (frameBusy !== 1'b0 && n < 600);
        chk("frame end", {frameBusy, activeIndex}, 4'h1);
        engineSdaDriveLow <= 1'b1;
        pins(3'h7);
        chk("wire low", {sharedSelectPinDataOeN, sharedSelectPinDataIn,
            sharedSelectPinDataOut}, 0);
        // pll 0 down spread, st0 low, st1 active; one setting per index
        acc(1'b1, 5'h04, 32'h1d);
        for (int k = 0; k < 8; k++)
            acc(1'b1, 5'(8 + k), 32'(k[0] + 2 * k[1] + 4 * k + 32 * k[0]));
        // first output st0 power-down, st1 active, role bit set
        acc(1'b1, WORD_GENERIC, 32'h4c);
        pins(3'h7);
        chk("role volatile", {engineEnable, activeIndex}, 4'h9);
        acc(1'b1, WORD_COMMAND, 32'h1);
        acc(1'b1, WORD_GENERIC, 32'h0);
        acc(1'b0, WORD_GENERIC, 32'h0);
        chk("busy write", q, 32'h4c);
        n = 0;
        do
        begin
            acc(1'b0, WORD_STATUS, 32'h0);
            n++;
        end
        while (q[STAT_BUSY_BIT] !== 1'b0 && n < 900);
        pins(3'h7);
        chk("selector role", {engineEnable, sharedSelectPinDataOeN}, 2'h1);
        chk("engine idle", {engineSdaIn, engineSclIn}, 2'h3);
        engineSdaDriveLow <= 1'b0;
        // every index applies its own setting
        for (int k = 0; k < 8; k++)
        begin
            pins(3'(k));
            chk("index", activeIndex, k);
            chk("ssc", spreadCodeField[0], k);
            chk("amount", spreadQuarterSteps[0], k == 7 ? 8 : k);
            chk("down", spreadDown[0], 1'b1);
            chk("fs", freqChoiceBit[0], k[1]);
            chk("pll0", pllOutputState[0], k[0] ? ST_ACTIVE : ST_DRIVE_LOW);
            chk("y1", firstOutputState, k[0] ? ST_ACTIVE : ST_POWER_DOWN);
            chk("pd", devicePowerDown, !k[0]);
        end
        // grounded supply brings the serial role back for a while
        outputSupplyGrounded <= 1'b1;
        pins(3'h7);
        chk("grounded", {engineEnable, activeIndex}, 4'h9);
        outputSupplyGrounded <= 1'b0;
        pins(3'h7);
        chk("released", {engineEnable, activeIndex}, 4'h7);
        stopTest();
    end
endmodule

`default_nettype wire
